// [core/iiec_ctrl.sv]
// I2C interrupt enable, event status, general call and clock stretch control
`default_nettype none

module iiec_ctrl
  import iiec_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR_RST = IIEC_OWN_ADDR_RST
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [IIEC_AW-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [IIEC_DW-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [IIEC_DW-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_tx_done,
  input wire logic i_rx_ready,
  input wire logic i_timeout,
  input wire logic i_arb_lost,
  input wire logic i_nack,
  input wire logic i_rx_overrun,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_o,
  output logic o_scl_oe,
  output logic o_sda_o,
  output logic o_sda_oe,
  output logic o_irq
);

  logic [IIEC_EN_W-1:0] enable;
  logic [IIEC_NEV-1:0] evt_status;
  logic [6:0] own_slave_address;
  logic stretch_point_select;
  iiec_state_e state;
  iiec_state_e next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] shreg;
  logic stretch_hold;
  logic next_stretch_hold;
  logic scl_d;
  logic sda_d;
  logic [1:0] pins_s;

  // Bus pins resynchronised before any logic looks at them
  iiec_sync #(
    .W(2),
    .RST_VAL(2'h3)
  ) u_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_d({i_scl, i_sda}),
    .o_q(pins_s)
  );

  wire scl_s = pins_s[1];
  wire sda_s = pins_s[0];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s;

  // Register bus decode
  wire bus_req = i_avs_read | i_avs_write;
  wire wr_commit = i_avs_write & ~o_avs_waitrequest;
  wire rd_load = i_avs_read & o_avs_waitrequest;
  wire sel_enable = i_avs_address == IIEC_OFS_ENABLE;
  wire sel_status = i_avs_address == IIEC_OFS_STATUS;
  wire sel_clear = i_avs_address == IIEC_OFS_CLEAR;
  wire sel_config = i_avs_address == IIEC_OFS_CONFIG;
  wire [15:0] lane_mask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  wire [15:0] wdata = i_avs_writedata[15:0];
  wire [15:0] wbits = wdata & lane_mask;
  wire wr_enable = wr_commit & sel_enable;
  wire wr_clear = wr_commit & sel_clear;
  wire wr_config = wr_commit & sel_config;

  // Only the eleven defined bits are stored; the rest read back as zero
  wire [IIEC_EN_W-1:0] en_mask = lane_mask[IIEC_EN_W-1:0];
  wire [IIEC_EN_W-1:0] next_enable =
    (enable & ~en_mask) | (wdata[IIEC_EN_W-1:0] & en_mask);

  wire [IIEC_NEV-1:0] clr_bits = wr_clear ? wbits[IIEC_NEV-1:0] : '0;
  wire str_en = enable[IIEC_STR_EN];
  wire gc_en = enable[IIEC_EV_GCALL];

  wire [15:0] cfg_word = {7'h00, stretch_point_select, 1'b0, own_slave_address};
  wire [15:0] en_word = {5'h00, enable};
  wire [15:0] st_word = {6'h00, evt_status};
  wire [15:0] rd_word =
    sel_enable ? en_word :
    sel_status ? st_word :
    sel_config ? cfg_word :
    16'h0000;

  // Address byte evaluation
  wire [6:0] rx_addr = shreg[7:1];
  wire addr_hit = (rx_addr == own_slave_address) && (rx_addr != IIEC_GC_ADDR);
  wire gc_hit = (rx_addr == IIEC_GC_ADDR) && gc_en;
  wire addr_done = (state == st_addr) && scl_fall && (bit_cnt == IIEC_CNT_BYTE);
  wire addr_evt = addr_done & addr_hit;
  wire gc_evt = addr_done & gc_hit;

  // Selected end of clock for stretching: eighth or ninth clock of a byte
  wire end_bit8 = scl_fall && (bit_cnt == IIEC_CNT_BYTE) &&
    ((state == st_data) || (addr_done && (addr_hit || gc_hit)));
  wire end_bit9 = scl_fall &&
    ((state == st_ack) || ((state == st_data) && (bit_cnt == IIEC_CNT_ACK)));
  wire stretch_point = (stretch_point_select == IIEC_SEL_BIT9) ? end_bit9 : end_bit8;
  wire stretch_go = str_en & stretch_point & ~stretch_hold;

  wire [IIEC_NEV-1:0] events = {
    i_rx_overrun,
    gc_evt,
    i_nack,
    i_arb_lost,
    addr_evt,
    i_timeout,
    stretch_go,
    i_rx_ready,
    i_tx_done,
    start_det
  };

  // Set wins over a clear in the same cycle
  wire [IIEC_NEV-1:0] next_status = (evt_status & ~clr_bits) | events;

  // Each flag gated by its own enable, merged into one level
  wire [IIEC_NEV-1:0] irq_src = evt_status & enable[IIEC_NEV-1:0];
  wire next_irq = |irq_src;

  // Link state machine
  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    case (state)
      st_idle: begin
        next_state = st_idle;
      end
      st_addr: begin
        if (scl_rise) begin
          next_bit_cnt = bit_cnt + 4'h1;
        end
        if (addr_done) begin
          next_state = (addr_hit || gc_hit) ? st_ack : st_skip;
        end
      end
      st_ack: begin
        if (scl_fall) begin
          next_state = st_data;
          next_bit_cnt = 4'h0;
        end
      end
      st_data: begin
        if (scl_rise) begin
          next_bit_cnt = bit_cnt + 4'h1;
        end else if (scl_fall && (bit_cnt == IIEC_CNT_ACK)) begin
          next_bit_cnt = 4'h0;
        end
      end
      st_skip: begin
        next_state = st_skip;
      end
      default: begin
        next_state = st_idle;
        next_bit_cnt = 4'h0;
      end
    endcase
    if (stop_det) begin
      next_state = st_idle;
      next_bit_cnt = 4'h0;
    end else if (start_det) begin
      next_state = st_addr;
      next_bit_cnt = 4'h0;
    end
  end

  // Stretch held until software clears its flag or turns stretching off
  always_comb begin
    next_stretch_hold = stretch_hold;
    if (stretch_go) begin
      next_stretch_hold = 1'b1;
    end else if (clr_bits[IIEC_EV_STRETCH]) begin
      next_stretch_hold = 1'b0;
    end
    if (!str_en) begin
      next_stretch_hold = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= '0;
    end else begin
      o_avs_waitrequest <= ~(bus_req & o_avs_waitrequest);
      if (rd_load) begin
        o_avs_readdata <= {16'h0000, rd_word};
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      enable <= IIEC_ENABLE_RST;
    end else if (wr_enable) begin
      enable <= next_enable;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      own_slave_address <= OWN_ADDR_RST;
      stretch_point_select <= IIEC_SEL_BIT8;
    end else if (wr_config) begin
      if (i_avs_byteenable[0]) begin
        own_slave_address <= wdata[IIEC_CFG_ADDR_LSB +: 7];
      end
      if (i_avs_byteenable[1]) begin
        stretch_point_select <= wdata[IIEC_CFG_SEL];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      evt_status <= '0;
      o_irq <= 1'b0;
    end else begin
      evt_status <= next_status;
      o_irq <= next_irq;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      shreg <= '0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      if (scl_rise) begin
        shreg <= {shreg[6:0], sda_s};
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state <= st_idle;
      bit_cnt <= 4'h0;
    end else begin
      state <= next_state;
      bit_cnt <= next_bit_cnt;
    end
  end

  // Open-drain outputs only ever pull low
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      stretch_hold <= 1'b0;
      o_scl_oe <= 1'b0;
      o_sda_oe <= 1'b0;
      o_scl_o <= 1'b0;
      o_sda_o <= 1'b0;
    end else begin
      stretch_hold <= next_stretch_hold;
      o_scl_oe <= next_stretch_hold;
      o_sda_oe <= next_state == st_ack;
      o_scl_o <= 1'b0;
      o_sda_o <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  a_timeout_irq: assert property (
    i_timeout && enable[IIEC_EV_TIMEOUT] |=> ##1 o_irq)
    else $error("timeout did not raise interrupt");

  a_amatch_flag: assert property (
    addr_evt && enable[IIEC_EV_AMATCH] |=> evt_status[IIEC_EV_AMATCH] ##1 o_irq)
    else $error("address match not flagged");

  a_arbloss_irq: assert property (
    i_arb_lost && enable[IIEC_EV_ARBLOSS] |=> ##1 o_irq)
    else $error("arbitration loss did not interrupt");

  a_nack_irq: assert property (
    i_nack && enable[IIEC_EV_NACK] |=> ##1 o_irq)
    else $error("nack did not interrupt");

  a_gcall_ignored: assert property (
    addr_done && rx_addr == IIEC_GC_ADDR && !gc_en |=>
    !o_sda_oe && !$rose(evt_status[IIEC_EV_GCALL]))
    else $error("general call answered while disabled");

  a_overrun_irq: assert property (
    i_rx_overrun && enable[IIEC_EV_OVERRUN] |=> ##1 o_irq)
    else $error("overrun did not interrupt");

  a_stretch_off: assert property (
    !str_en |=> !o_scl_oe)
    else $error("clock stretched while disabled");

  a_stretch_hold: assert property (
    stretch_go |=> o_scl_oe[*2])
    else $error("stretch point did not hold clock");

  a_reserved_zero: assert property (
    rd_load && sel_enable |=> o_avs_readdata[31:IIEC_EN_W] == '0)
    else $error("reserved enable bits read non-zero");

  a_reset_clear: assert property (disable iff (1'b0)
    !i_nrst |=> enable == '0 && !o_irq)
    else $error("enable register not cleared by reset");

  a_low_enables: assert property (
    i_tx_done && enable[IIEC_EV_TX] |=> ##1 o_irq)
    else $error("transmit flag did not interrupt");

  a_irq_level: assert property (
    $past(i_nrst) |-> o_irq == $past(next_irq))
    else $error("interrupt level disagrees with gated flags");

  a_bus_answer: assert property (
    bus_req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus request not answered in one cycle");

  c_gcall: cover property (gc_evt ##[1:400] o_sda_oe);
  c_stretch: cover property (stretch_go ##1 o_scl_oe ##[1:50] !o_scl_oe);
  c_irq_rise: cover property (!o_irq ##1 o_irq);
  c_set_clear: cover property (wr_clear && |(clr_bits & events));

endmodule // iiec_ctrl

`default_nettype wire

// [core/iiec_sync.sv]
// Two-stage synchroniser for pins from outside the clock domain
`default_nettype none

module iiec_sync #(
  parameter int unsigned W = 2,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      meta <= RST_VAL;
      o_q <= RST_VAL;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule // iiec_sync

`default_nettype wire

// [dv/iiec_ctrl_test.sv]
// Self-checking bench for the interrupt enable and stretch control block
`default_nettype none

module iiec_ctrl_test;
  import iiec_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [IIEC_AW-1:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [IIEC_DW-1:0] wd = '0;
  logic [3:0] be = 4'hf;
  logic [9:0] ev = '0;
  logic saw_str = 1'b0;
  wire logic [IIEC_DW-1:0] rdat;
  wire logic wreq, scl_o, scl_oe, sda_o, sda_oe, irq, m_scl, m_sda, scl, sda;
  int fails = 0;
  int total_checks = 0;
  assign scl = !(m_scl | (scl_oe & !scl_o));
  assign sda = !(m_sda | (sda_oe & !sda_o));
  always #20 i_clk = !i_clk;
  always @(posedge i_clk) if (scl_oe === 1'b1) saw_str <= 1'b1;

  iiec_ctrl DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_tx_done(ev[IIEC_EV_TX]), .i_rx_ready(ev[IIEC_EV_RX]),
    .i_timeout(ev[IIEC_EV_TIMEOUT]), .i_arb_lost(ev[IIEC_EV_ARBLOSS]), .i_nack(ev[IIEC_EV_NACK]),
    .i_rx_overrun(ev[IIEC_EV_OVERRUN]), .i_scl(scl), .i_sda(sda), .o_scl_o(scl_o),
    .o_scl_oe(scl_oe), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_irq(irq));
  iiec_i2c_host host (.i_scl(scl), .i_sda(sda), .o_scl_low(m_scl), .o_sda_low(m_sda));

  task automatic results;
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    @(posedge i_clk);
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= d;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    if (wreq !== 1'b0) begin
      fails++;
      results();
    end
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  function automatic logic exp_irq(input logic [31:0] en, input logic [31:0] st);
    return |(en[9:0] & st[9:0]);
  endfunction

  int evs[6] = '{IIEC_EV_TX, IIEC_EV_RX, IIEC_EV_TIMEOUT, IIEC_EV_ARBLOSS, IIEC_EV_NACK,
    IIEC_EV_OVERRUN};
  // Address byte, enables, expected ack, expected status
  logic [31:0] cases[4][4] = '{'{32'ha0, 32'h021, 32'h1, 32'h021},
    '{32'ha2, 32'h021, 32'h0, 32'h001}, '{32'h00, 32'h001, 32'h0, 32'h001},
    '{32'h00, 32'h101, 32'h1, 32'h101}};

  initial begin
    logic [31:0] q;
    logic [31:0] en;
    logic ack;
    int n;
    logic [6:0] own;
    void'($urandom(45));
    wt(4);
    i_nrst <= 1'b1;
    bus(0, IIEC_OFS_ENABLE, 0, q); chk("enable", 32'h0, q);
    bus(0, IIEC_OFS_STATUS, 0, q); chk("status", 32'h0, q);
    bus(0, IIEC_OFS_CONFIG, 0, q); chk("config", {25'h0, IIEC_OWN_ADDR_RST}, q);
    bus(1, IIEC_OFS_ENABLE, 32'hffffffff, q);
    bus(0, IIEC_OFS_ENABLE, 0, q); chk("enable", 32'h7ff, q);
    be <= 4'h1;
    bus(1, IIEC_OFS_ENABLE, 32'h0, q);
    be <= 4'hf;
    bus(0, IIEC_OFS_ENABLE, 0, q); chk("enable", 32'h700, q);
    bus(0, 5'h10, 0, q); chk("unmapped", 32'h0, q);
    for (int p = 0; p < 2; p++) begin
      foreach (evs[k]) begin
        en = $urandom & 32'h3ff;
        en[evs[k]] = p[0];
        bus(1, IIEC_OFS_ENABLE, en, q);
        ev[evs[k]] <= 1'b1;
        @(posedge i_clk);
        ev <= '0;
        wt(3);
        bus(0, IIEC_OFS_STATUS, 0, q); chk("status", 32'h1 << evs[k], q);
        chk_bit("irq", exp_irq(en, 32'h1 << evs[k]), irq);
        bus(1, IIEC_OFS_CLEAR, 32'h3ff, q);
        wt(2);
        chk_bit("irq", 1'b0, irq);
      end
    end
    foreach (cases[c]) begin
      bus(1, IIEC_OFS_ENABLE, cases[c][1], q);
      host.start();
      host.put_byte(cases[c][0][7:0], ack);
      host.stop();
      wt(5);
      chk_bit("ack", cases[c][2][0], ack);
      bus(0, IIEC_OFS_STATUS, 0, q); chk("status", cases[c][3], q);
      chk_bit("irq", exp_irq(cases[c][1], q), irq);
      bus(1, IIEC_OFS_CLEAR, 32'h3ff, q);
    end
    chk_bit("stretch idle", 1'b0, saw_str);
    // Stretch at the end of the eighth clock, then of the ninth with a new own address
    for (int s = 0; s < 2; s++) begin
      own = s[0] ? 7'h2a : IIEC_OWN_ADDR_RST;
      bus(1, IIEC_OFS_CONFIG, {23'h0, s[0], 1'b0, own}, q);
      bus(1, IIEC_OFS_ENABLE, 32'h408, q);
      fork
        begin
          host.start();
          host.put_byte({own, 1'b0}, ack);
          host.stop();
        end
        begin
          n = 0;
          while (scl_oe !== 1'b1 && n < 400) begin
            @(posedge i_clk);
            n++;
          end
          if (scl_oe !== 1'b1) begin
            fails++;
            results();
          end
          wt(20);
          chk_bit("scl", 1'b0, scl);
          chk_bit("ack drive", !s[0], sda_oe);
          bus(0, IIEC_OFS_STATUS, 0, q); chk("status", 32'h029, q);
          chk_bit("irq", 1'b1, irq);
          bus(1, IIEC_OFS_CLEAR, 32'h008, q);
        end
      join
      chk_bit("ack", 1'b1, ack);
    end
    chk_bit("host stuck", 1'b0, host.stuck);
    @(posedge i_clk);
    i_nrst <= 1'b0;
    wt(2);
    i_nrst <= 1'b1;
    bus(0, IIEC_OFS_ENABLE, 0, q); chk("enable", 32'h0, q);
    bus(0, IIEC_OFS_CONFIG, 0, q); chk("config", {25'h0, IIEC_OWN_ADDR_RST}, q);
    results();
  end
endmodule // iiec_ctrl_test

`default_nettype wire

// [dv/iiec_i2c_host.sv]
// Behavioural bus master on the I2C pins, open drain against a pull-up
`default_nettype none

module iiec_i2c_host (
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_low,
  output logic o_sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int QT = 80;
  logic stuck;

  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
    stuck = 1'b0;
  end

  // Release SCL and wait out any stretch, bounded
  task automatic rise_scl;
    int n;
    n = 0;
    #QT o_scl_low = 1'b0;
    #1;
    while (i_scl !== 1'b1 && n < 40000) begin
      #1;
      n++;
    end
    if (i_scl !== 1'b1) begin
      stuck = 1'b1;
    end
  endtask

  task automatic start;
    #7 o_sda_low = 1'b1;
    #QT o_scl_low = 1'b1;
    #QT;
  endtask

  task automatic stop;
    #QT o_sda_low = 1'b1;
    rise_scl();
    #QT o_sda_low = 1'b0;
    #QT;
  endtask

  // Eight bits MSB first, then the acknowledge slot
  task automatic put_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #QT o_sda_low = !d[i];
      rise_scl();
      #(2 * QT - 1) o_scl_low = 1'b1;
    end
    #QT o_sda_low = 1'b0;
    rise_scl();
    #QT ack = !i_sda;
    #(QT - 1) o_scl_low = 1'b1;
  endtask
endmodule // iiec_i2c_host

`default_nettype wire

// [inc/iiec_pkg.sv]
// Constants and types for the I2C interrupt enable and stretch control block
//
// Notes on behaviour
// - Timeout flag interrupts the CPU only while its enable bit is set.
// - Own slave address match interrupts the CPU only while its enable is set.
// - Arbitration loss flag interrupts the CPU only while its enable is set.
// - NACK flag interrupts the CPU only while its enable is set.
// - General call address is answered and flagged only while its enable is set.
// - Receiver overrun flag interrupts the CPU only while its enable is set.
// - Stretch enable holds SCL low at the selected clock end; cleared, never stretch.
// - Upper 21 bits of the enable register always read as zero.
// - Enable register clears to zero on every reset.
// - Start, transmit, receive and stretch flags gated by the four lowest enables.
`default_nettype none

package iiec_pkg;
  localparam int unsigned IIEC_AW = 5;
  localparam int unsigned IIEC_DW = 32;
  localparam logic [IIEC_AW-1:0] IIEC_OFS_ENABLE = 5'h00;
  localparam logic [IIEC_AW-1:0] IIEC_OFS_STATUS = 5'h04;
  localparam logic [IIEC_AW-1:0] IIEC_OFS_CLEAR = 5'h08;
  localparam logic [IIEC_AW-1:0] IIEC_OFS_CONFIG = 5'h0c;
  // Event bit positions, shared by enable, status and clear
  localparam int unsigned IIEC_EV_START = 0;
  localparam int unsigned IIEC_EV_TX = 1;
  localparam int unsigned IIEC_EV_RX = 2;
  localparam int unsigned IIEC_EV_STRETCH = 3;
  localparam int unsigned IIEC_EV_TIMEOUT = 4;
  localparam int unsigned IIEC_EV_AMATCH = 5;
  localparam int unsigned IIEC_EV_ARBLOSS = 6;
  localparam int unsigned IIEC_EV_NACK = 7;
  localparam int unsigned IIEC_EV_GCALL = 8;
  localparam int unsigned IIEC_EV_OVERRUN = 9;
  localparam int unsigned IIEC_NEV = 10;
  localparam int unsigned IIEC_STR_EN = 10;
  localparam int unsigned IIEC_EN_W = 11;
  localparam logic [IIEC_EN_W-1:0] IIEC_ENABLE_RST = 11'h000;
  // Config register fields
  localparam int unsigned IIEC_CFG_ADDR_LSB = 0;
  localparam int unsigned IIEC_CFG_SEL = 8;
  localparam logic [6:0] IIEC_OWN_ADDR_RST = 7'h50;
  localparam logic [6:0] IIEC_GC_ADDR = 7'h00;
  localparam logic IIEC_SEL_BIT8 = 1'b0;
  localparam logic IIEC_SEL_BIT9 = 1'b1;
  localparam logic [3:0] IIEC_CNT_BYTE = 4'h8;
  localparam logic [3:0] IIEC_CNT_ACK = 4'h9;
  typedef enum logic [4:0] {
    st_idle = 5'b00001,
    st_addr = 5'b00010,
    st_ack = 5'b00100,
    st_data = 5'b01000,
    st_skip = 5'b10000
  } iiec_state_e;
endpackage

`default_nettype wire
